// ---- rtl/dram_init_power_refresh.sv ----
// Start-up, power mode, refresh and current calibration core of a packet DRAM
//
// Functional notes
// - Held reset packets force known state, start lock
// - No request accepted until lock time passes
// - Controller reads and writes all control registers
// - Stay-enabled flag keeps device in enable mode
// - Wake enters enable; suspend after transaction ends
// - Wake packets may overlap other packets
// - Powerdown request bit write enters powerdown
// - Held powerdown-wake packets start clock relock
// - Enable mode after lock following powerdown exit
// - Refresh activates then auto-precharges the row
// - Lock completes within five microseconds
// - Every packet lasts four link cycles
`timescale 1ns/1ns
`default_nettype none
module dram_init_power_refresh #(
	parameter int unsigned RESET_PKTS  = dram_pkg::RESET_PKTS_MIN,
	parameter int unsigned WAKE_PKTS   = dram_pkg::WAKE_PKTS_MIN,
	parameter int unsigned LOCK_CYCLES = dram_pkg::LOCK_CYC
) (
	input  wire logic                          clock,
	input  wire logic                          resetn,
	input  wire logic                          link_clk,
	input  wire logic                          cmd_wire,
	input  wire logic [dram_pkg::LANE_W-1:0]   bus_data,
	input  wire logic                          lowpower_refresh_strobe,
	input  wire logic [dram_pkg::REG_AW-1:0]   reg_addr,
	input  wire logic [dram_pkg::REG_DW-1:0]   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [dram_pkg::REG_DW-1:0]   reg_rdata,
	output logic      [2:0]                    power_mode,
	output logic                               locked,
	output logic                               refresh_pulse,
	output logic      [dram_pkg::BANK_W-1:0]   refresh_bank,
	output logic      [dram_pkg::ROW_W-1:0]    refresh_row,
	output logic                               calib_pulse,
	output logic                               calibrated
);
	import dram_pkg::*;

	localparam int unsigned ASYNC_W = LANE_W + 3;
	localparam int unsigned LOCK_W  = $clog2(LOCK_CYCLES + 1);
	localparam int unsigned RUN_W   = 4;
	localparam logic [BUSY_W-1:0] REFRESH_BEATS = BUSY_W'(REFRESH_PKTS * PKT_BEATS);
	localparam logic [BUSY_W-1:0] XFER_BEATS    = BUSY_W'(XFER_PKTS * PKT_BEATS);

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [ASYNC_W-1:0] sync1_ff;
	logic [ASYNC_W-1:0] sync2_ff;
	logic               link_d_ff;
	logic               strobe_d_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_ff    <= '0;
			sync2_ff    <= '0;
			link_d_ff   <= 1'b0;
			strobe_d_ff <= 1'b0;
		end else begin
			sync1_ff    <= {link_clk, cmd_wire, lowpower_refresh_strobe, bus_data};
			sync2_ff    <= sync1_ff;
			link_d_ff   <= sync2_ff[ASYNC_W-1];
			strobe_d_ff <= sync2_ff[LANE_W];
		end
	end

	wire link_rise   = sync2_ff[ASYNC_W-1] & ~link_d_ff;
	wire strobe_rise = sync2_ff[LANE_W] & ~strobe_d_ff;

	pkt_if pkt ();
	assign pkt.link_edge = link_rise;
	assign pkt.cmd_bit   = sync2_ff[ASYNC_W-2];
	assign pkt.data_bits = sync2_ff[LANE_W-1:0];

	packet_rx u_rx (
		.clock  (clock),
		.resetn (resetn),
		.pkt    (pkt)
	);

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	power_state_t      state_ff;
	power_state_t      nxt_state;
	logic [LOCK_W-1:0] lock_cnt_ff;
	logic [RUN_W-1:0]  rst_run_ff;
	logic [RUN_W-1:0]  pdw_run_ff;
	logic [BUSY_W-1:0] busy_ff;
	logic              stay_en_ff;
	logic [DEV_W-1:0]  dev_id_ff;
	logic [BANK_W-1:0] ptr_bank_ff;
	logic [ROW_W-1:0]  ptr_row_ff;
	logic [7:0]        cal_cnt_ff;
	logic [15:0]       ref_cnt_ff;
	logic              dropped_ff;
	logic              calibrated_ff;
	logic              locked_ff;
	logic              refresh_pulse_ff;
	logic [BANK_W-1:0] refresh_bank_ff;
	logic [ROW_W-1:0]  refresh_row_ff;
	logic              calib_pulse_ff;
	logic [REG_DW-1:0] rdata_ff;

	// ----------------------------------------------------------------
	// Command wire decode
	// ----------------------------------------------------------------
	wire cmd_reset = pkt.cmd_valid && (pkt.cmd_code == CMD_RESET);
	wire cmd_wake  = pkt.cmd_valid && (pkt.cmd_code == CMD_WAKE);
	wire cmd_pdwk  = pkt.cmd_valid && (pkt.cmd_code == CMD_PDWK);

	// Reset only counts once packets were held long enough back to back
	wire chan_reset = cmd_reset && (rst_run_ff >= RUN_W'(RESET_PKTS - 1));
	wire pd_wake_done = cmd_pdwk && (state_ff == st_powerdown)
	                    && (pdw_run_ff >= RUN_W'(WAKE_PKTS - 1));

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	wire [OP_W-1:0]   rq_op   = pkt.req_word[OP_LSB +: OP_W];
	wire [MASK_W-1:0] rq_mask = pkt.req_word[MASK_LSB +: MASK_W];
	wire [DEV_W-1:0]  rq_dev  = pkt.req_word[DEV_LSB +: DEV_W];
	wire [BANK_W-1:0] rq_bank = pkt.req_word[BANK_LSB +: BANK_W];
	wire [ROW_W-1:0]  rq_addr = pkt.req_word[ADDR_LSB +: ROW_W];
	wire              rq_auto = pkt.req_word[AUTO_BIT];
	wire              rq_activate_bit = pkt.req_word[ACT_BIT];
	wire              rq_rsel = pkt.req_word[RSEL_BIT];

	// Requests outside enable mode (lock, suspend without wake, powerdown) are dropped
	wire req_ok      = pkt.req_valid && (state_ff == st_enable) && (busy_ff == '0);
	wire req_dropped = pkt.req_valid && !req_ok;
	// The pending-count field is carried but need not be checked by the device
	wire is_refresh  = (rq_op == OP_REFRESH) && rq_auto && rq_activate_bit && !rq_rsel
	                   && (rq_mask == MASK_NONE);
	wire is_cal      = (rq_op == OP_CAL) && (rq_addr == CAL_COL) && !rq_rsel;
	wire req_refresh = req_ok && is_refresh;
	wire req_cal     = req_ok && is_cal && (rq_dev == dev_id_ff);
	wire req_xfer    = req_ok && !is_refresh && !is_cal;
	wire busy_end    = link_rise && (busy_ff == BUSY_W'(1));
	wire pd_refresh  = strobe_rise && (state_ff == st_powerdown);

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	wire wr_mode   = reg_wr && (reg_addr == REG_MODE);
	wire wr_refptr = reg_wr && (reg_addr == REG_REFPTR);
	wire wr_devid  = reg_wr && (reg_addr == REG_DEVID);
	wire wr_status = reg_wr && (reg_addr == REG_STATUS);
	wire pd_enter  = wr_refptr && reg_wdata[PD_REQ_BIT]
	                 && ((state_ff == st_enable) || (state_ff == st_suspend));

	wire [REG_DW-1:0] status_word = REG_DW'({dropped_ff, calibrated_ff, locked_ff, 3'(state_ff)});
	wire [REG_DW-1:0] rd_mux =
		(reg_addr == REG_MODE)   ? REG_DW'(stay_en_ff) :
		(reg_addr == REG_REFPTR) ? REG_DW'({ptr_bank_ff, ptr_row_ff}) :
		(reg_addr == REG_DEVID)  ? REG_DW'(dev_id_ff) :
		(reg_addr == REG_STATUS) ? status_word :
		(reg_addr == REG_CALCNT) ? REG_DW'(cal_cnt_ff) :
		(reg_addr == REG_REFCNT) ? ref_cnt_ff : '0;

	// Bank is the low part so it steps fastest between self-refreshes
	wire [BANK_W+ROW_W-1:0] ptr_next = {ptr_row_ff, ptr_bank_ff} + 1'b1;

	// ----------------------------------------------------------------
	// Power mode sequencing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		if (chan_reset) begin
			nxt_state = st_lock;
		end else begin
			unique case (state_ff)
				st_off: begin
					nxt_state = st_off;
				end
				st_lock: begin
					if (lock_cnt_ff == '0) begin
						nxt_state = st_enable;
					end
				end
				st_enable: begin
					if (pd_enter) begin
						nxt_state = st_powerdown;
					end else if (busy_end && !stay_en_ff) begin
						nxt_state = st_suspend;
					end
				end
				st_suspend: begin
					if (pd_enter) begin
						nxt_state = st_powerdown;
					end else if (stay_en_ff || cmd_wake) begin
						nxt_state = st_enable;
					end
				end
				st_powerdown: begin
					if (pd_wake_done) begin
						nxt_state = st_lock;
					end
				end
				default: begin
					nxt_state = st_off;
				end
			endcase
		end
	end

	wire enter_lock = (nxt_state == st_lock) && (state_ff != st_lock || chan_reset);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff    <= st_off;
			lock_cnt_ff <= '0;
			locked_ff   <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			locked_ff   <= (nxt_state == st_enable) || (nxt_state == st_suspend);
			if (enter_lock) begin
				lock_cnt_ff <= LOCK_W'(LOCK_CYCLES - 1);
			end else if (lock_cnt_ff != '0) begin
				lock_cnt_ff <= lock_cnt_ff - 1'b1;
			end
		end
	end

	// Consecutive packet counters; any other command packet breaks the run
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_run_ff <= '0;
			pdw_run_ff <= '0;
		end else if (pkt.cmd_valid) begin
			rst_run_ff <= (cmd_reset && rst_run_ff != '1) ? rst_run_ff + 1'b1 : (cmd_reset ? rst_run_ff : '0);
			pdw_run_ff <= (cmd_pdwk && pdw_run_ff != '1) ? pdw_run_ff + 1'b1 : (cmd_pdwk ? pdw_run_ff : '0);
		end
	end

	// Transaction occupancy in link beats; keeps enable mode until it ends
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy_ff <= '0;
		end else if (chan_reset) begin
			busy_ff <= '0;
		end else if (req_refresh) begin
			busy_ff <= REFRESH_BEATS;
		end else if (req_xfer || req_cal) begin
			busy_ff <= XFER_BEATS;
		end else if (link_rise && busy_ff != '0) begin
			busy_ff <= busy_ff - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control registers; a channel reset restores their defaults
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stay_en_ff  <= STAY_EN_RST;
			dev_id_ff   <= DEVID_RST;
			ptr_bank_ff <= '0;
			ptr_row_ff  <= '0;
		end else if (chan_reset) begin
			stay_en_ff  <= STAY_EN_RST;
			dev_id_ff   <= DEVID_RST;
			ptr_bank_ff <= '0;
			ptr_row_ff  <= '0;
		end else begin
			if (wr_mode) begin
				stay_en_ff <= reg_wdata[STAY_EN_BIT];
			end
			if (wr_devid) begin
				dev_id_ff <= reg_wdata[DEV_W-1:0];
			end
			if (wr_refptr) begin
				ptr_bank_ff <= reg_wdata[PTR_BANK_LSB +: BANK_W];
				ptr_row_ff  <= reg_wdata[PTR_ROW_LSB +: ROW_W];
			end else if (pd_refresh) begin
				{ptr_row_ff, ptr_bank_ff} <= ptr_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Refresh and calibration results
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			refresh_pulse_ff <= 1'b0;
			refresh_bank_ff  <= '0;
			refresh_row_ff   <= '0;
			ref_cnt_ff       <= '0;
			calib_pulse_ff   <= 1'b0;
			cal_cnt_ff       <= '0;
			calibrated_ff    <= 1'b0;
		end else begin
			refresh_pulse_ff <= req_refresh || pd_refresh;
			calib_pulse_ff   <= req_cal;
			if (req_refresh) begin
				refresh_bank_ff <= rq_bank;
				refresh_row_ff  <= rq_addr;
			end else if (pd_refresh) begin
				refresh_bank_ff <= ptr_bank_ff;
				refresh_row_ff  <= ptr_row_ff;
			end
			if (req_refresh || pd_refresh) begin
				ref_cnt_ff <= ref_cnt_ff + 1'b1;
			end
			// Every lock loses the calibration, so the burst must be repeated
			if (enter_lock) begin
				cal_cnt_ff    <= '0;
				calibrated_ff <= 1'b0;
			end else if (req_cal) begin
				cal_cnt_ff    <= (cal_cnt_ff == '1) ? cal_cnt_ff : cal_cnt_ff + 1'b1;
				calibrated_ff <= calibrated_ff || (cal_cnt_ff == 8'(CAL_BURST - 1));
			end
		end
	end

	// Dropped-request flag: a new drop in the clearing cycle wins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dropped_ff <= 1'b0;
		end else begin
			dropped_ff <= req_dropped || (dropped_ff && !(wr_status && reg_wdata[ST_DROP_BIT]));
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : '0;
		end
	end

	assign reg_rdata     = rdata_ff;
	assign power_mode    = state_ff;
	assign locked        = locked_ff;
	assign refresh_pulse = refresh_pulse_ff;
	assign refresh_bank  = refresh_bank_ff;
	assign refresh_row   = refresh_row_ff;
	assign calib_pulse   = calib_pulse_ff;
	assign calibrated    = calibrated_ff;

endmodule
`default_nettype wire

// ---- common/dram_pkg.sv ----
// Shared constants and types for the packet DRAM start-up, power and refresh logic
package dram_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned LOCK_TIME_NS   = 5000;
	localparam int unsigned LOCK_CYC       = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned PKT_BEATS      = 4;
	localparam int unsigned BEAT_W         = $clog2(PKT_BEATS);
	localparam int unsigned RESET_PKTS_MIN = 4;
	localparam int unsigned WAKE_PKTS_MIN  = 2;
	localparam int unsigned REFRESH_PKTS   = 4;
	localparam int unsigned XFER_PKTS      = 2;
	localparam int unsigned BUSY_W         = 5;
	localparam int unsigned CAL_BURST      = 64;

	// ----------------------------------------------------------------
	// Request packet layout: four 9-bit beats, first beat highest
	// ----------------------------------------------------------------
	localparam int unsigned LANE_W       = 9;
	localparam int unsigned PKT_W        = LANE_W * PKT_BEATS;
	localparam int unsigned START_BIT    = 35;
	localparam int unsigned ACT_BIT      = 34;
	localparam int unsigned AUTO_BIT     = 33;
	localparam int unsigned OP_LSB       = 27;
	localparam int unsigned OP_W         = 6;
	localparam int unsigned RSEL_BIT     = 26;
	localparam int unsigned MASK_LSB     = 18;
	localparam int unsigned MASK_W       = 8;
	localparam int unsigned DEV_LSB      = 14;
	localparam int unsigned DEV_W        = 4;
	localparam int unsigned BANK_LSB     = 12;
	localparam int unsigned BANK_W       = 2;
	localparam int unsigned PCNT_LSB     = 9;
	localparam int unsigned PCNT_W       = 3;
	localparam int unsigned ADDR_LSB     = 0;
	localparam int unsigned ROW_W        = 8;

	localparam logic [OP_W-1:0]   OP_REFRESH = 6'h09;
	localparam logic [OP_W-1:0]   OP_CAL     = 6'h06;
	localparam logic [ROW_W-1:0]  CAL_COL    = 8'h05;
	localparam logic [MASK_W-1:0] MASK_NONE  = 8'h00;

	// Command wire packet codes (three bits after a start beat)
	localparam int unsigned CMD_W     = 3;
	localparam logic [2:0]  CMD_RESET = 3'h7;
	localparam logic [2:0]  CMD_WAKE  = 3'h1;
	localparam logic [2:0]  CMD_PDWK  = 3'h2;

	// ----------------------------------------------------------------
	// Register port map
	// ----------------------------------------------------------------
	localparam int unsigned REG_AW = 3;
	localparam int unsigned REG_DW = 16;
	localparam logic [2:0] REG_MODE   = 3'h0;
	localparam logic [2:0] REG_REFPTR = 3'h1;
	localparam logic [2:0] REG_DEVID  = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_CALCNT = 3'h4;
	localparam logic [2:0] REG_REFCNT = 3'h5;

	localparam int unsigned STAY_EN_BIT  = 0;
	localparam int unsigned PD_REQ_BIT   = 15;
	localparam int unsigned PTR_BANK_LSB = 8;
	localparam int unsigned PTR_ROW_LSB  = 0;
	localparam int unsigned ST_LOCK_BIT  = 3;
	localparam int unsigned ST_CAL_BIT   = 4;
	localparam int unsigned ST_DROP_BIT  = 5;

	localparam logic             STAY_EN_RST = 1'b1;
	localparam logic [DEV_W-1:0] DEVID_RST   = 4'h0;

	typedef enum logic [2:0] {
		st_off,
		st_lock,
		st_enable,
		st_suspend,
		st_powerdown
	} power_state_t;

endpackage

// ---- common/pkt_if.sv ----
// Carrier between the channel deserialiser and the power/refresh core
`timescale 1ns/1ns
`default_nettype none
interface pkt_if;
	import dram_pkg::*;
	logic                    link_edge;
	logic                    cmd_bit;
	logic [LANE_W-1:0]       data_bits;
	logic                    cmd_valid;
	logic [CMD_W-1:0]        cmd_code;
	logic                    req_valid;
	logic [PKT_W-1:0]        req_word;

	modport rx (
		input  link_edge,
		input  cmd_bit,
		input  data_bits,
		output cmd_valid,
		output cmd_code,
		output req_valid,
		output req_word
	);
	modport core (
		output link_edge,
		output cmd_bit,
		output data_bits,
		input  cmd_valid,
		input  cmd_code,
		input  req_valid,
		input  req_word
	);
endinterface
`default_nettype wire

// ---- rtl/packet_rx.sv ----
// Deserialiser for command-wire and request packets, four link beats each
`timescale 1ns/1ns
`default_nettype none
module packet_rx (
	input wire logic clock,
	input wire logic resetn,
	pkt_if.rx        pkt
);
	import dram_pkg::*;

	localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(PKT_BEATS - 1);

	logic              cmd_busy_ff;
	logic [BEAT_W-1:0] cmd_beat_ff;
	logic [CMD_W-1:0]  cmd_bits_ff;
	logic              req_busy_ff;
	logic [BEAT_W-1:0] req_beat_ff;
	logic [PKT_W-1:0]  req_bits_ff;

	wire [CMD_W-1:0] cmd_shift = {cmd_bits_ff[CMD_W-2:0], pkt.cmd_bit};
	wire [PKT_W-1:0] req_shift = {req_bits_ff[PKT_W-LANE_W-1:0], pkt.data_bits};

	// ----------------------------------------------------------------
	// Command wire: a high start beat, then the code beats
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmd_busy_ff   <= 1'b0;
			cmd_beat_ff   <= '0;
			cmd_bits_ff   <= '0;
			pkt.cmd_valid <= 1'b0;
			pkt.cmd_code  <= '0;
		end else begin
			pkt.cmd_valid <= 1'b0;
			if (pkt.link_edge) begin
				cmd_bits_ff <= cmd_shift;
				cmd_beat_ff <= cmd_busy_ff ? cmd_beat_ff + 1'b1 : BEAT_W'(1);
				if (!cmd_busy_ff) begin
					cmd_busy_ff <= pkt.cmd_bit;
				end else if (cmd_beat_ff == LAST_BEAT) begin
					cmd_busy_ff   <= 1'b0;
					pkt.cmd_valid <= 1'b1;
					pkt.cmd_code  <= cmd_shift;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Data wires: the top lane marks the first beat of a request
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			req_busy_ff   <= 1'b0;
			req_beat_ff   <= '0;
			req_bits_ff   <= '0;
			pkt.req_valid <= 1'b0;
			pkt.req_word  <= '0;
		end else begin
			pkt.req_valid <= 1'b0;
			if (pkt.link_edge) begin
				req_bits_ff <= req_shift;
				req_beat_ff <= req_busy_ff ? req_beat_ff + 1'b1 : BEAT_W'(1);
				if (!req_busy_ff) begin
					req_busy_ff <= pkt.data_bits[LANE_W-1];
				end else if (req_beat_ff == LAST_BEAT) begin
					req_busy_ff   <= 1'b0;
					pkt.req_valid <= 1'b1;
					pkt.req_word  <= req_shift;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- sim/dram_checker.sv ----
// Concurrent checks on the ports of the power and refresh core
`timescale 1ns/1ns
`default_nettype none
module dram_checker #(
	parameter int unsigned LOCK_CYCLES = dram_pkg::LOCK_CYC
) (
	input wire logic                        clock,
	input wire logic                        resetn,
	input wire logic [dram_pkg::REG_AW-1:0] reg_addr,
	input wire logic [dram_pkg::REG_DW-1:0] reg_wdata,
	input wire logic                        reg_wr,
	input wire logic                        reg_rd,
	input wire logic [dram_pkg::REG_DW-1:0] reg_rdata,
	input wire logic [2:0]                  power_mode,
	input wire logic                        locked,
	input wire logic                        refresh_pulse,
	input wire logic                        calib_pulse,
	input wire logic                        calibrated
);
	import dram_pkg::*;
	logic [7:0] lk_ff;
	logic [7:0] nxt_lk;
	wire        pd_req = reg_wr && reg_addr == REG_REFPTR && reg_wdata[PD_REQ_BIT];
	assign nxt_lk = (power_mode == 3'h1) ? lk_ff + 8'h01 : 8'h00;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			lk_ff <= 8'h00;
		else
			lk_ff <= nxt_lk;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	a_locked_flag: assert property (locked == (power_mode inside {3'h2, 3'h3}))
		else $error("locked flag disagrees with power mode");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_pd_enter: assert property (pd_req && power_mode inside {3'h2, 3'h3} |=> power_mode == 3'h4)
		else $error("powerdown request not taken");
	a_pd_ignore: assert property (pd_req && power_mode inside {3'h0, 3'h1} |=> power_mode != 3'h4)
		else $error("powerdown entered before lock");
	a_lock_exit: assert property ($past(power_mode) == 3'h1 && power_mode != 3'h1 |-> power_mode == 3'h2)
		else $error("lock left to a mode other than enable");
	a_lock_bound: assert property (power_mode == 3'h1 |-> lk_ff <= LOCK_CYCLES + 2)
		else $error("lock lasts too long");
	a_pulse_single: assert property (refresh_pulse |=> !refresh_pulse [*3])
		else $error("refresh pulse repeated");
	a_calib_enable: assert property (calib_pulse |-> power_mode == 3'h2)
		else $error("calibration outside enable mode");
	a_quiet_unlocked: assert property (power_mode inside {3'h0, 3'h1} |-> !refresh_pulse && !calib_pulse)
		else $error("activity before lock completes");
	a_cal_clear: assert property (power_mode == 3'h1 ##1 power_mode == 3'h1 |-> !calibrated)
		else $error("calibrated flag kept through lock");
endmodule
bind dram_init_power_refresh dram_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (.clock, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_mode, .locked, .refresh_pulse, .calib_pulse, .calibrated);
`default_nettype wire

// ---- sim/ctrl_model.sv ----
// Behavioural channel controller: link clock, command wire, lanes, refresh strobe
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
	input wire logic                        clock,
	output logic                            link_clk,
	output logic                            cmd_wire,
	output logic [dram_pkg::LANE_W-1:0]     bus_data,
	output logic                            lowpower_refresh_strobe
);
	import dram_pkg::*;
	// Runs free: the device locks to it, also between frames
	initial begin
		link_clk = 1'b0;
		cmd_wire = 1'b0;
		bus_data = '0;
		lowpower_refresh_strobe = 1'b0;
		forever #200 link_clk = ~link_clk;
	end
	// Lanes change after a falling link edge, so each beat is stable at the rising one
	task automatic beat(input logic c, input logic [LANE_W-1:0] d);
		@(negedge link_clk);
		@(posedge clock);
		cmd_wire <= c;
		bus_data <= d;
	endtask
	// Terminated lanes rest low
	task automatic idle();
		beat(1'b0, '0);
	endtask
	task automatic pkt(input logic [2:0] code, input logic cmd, input logic [PKT_W-1:0] w);
		beat(cmd, w[35:27]);
		beat(code[2], w[26:18]);
		beat(code[1], w[17:9]);
		beat(code[0], w[8:0]);
	endtask
	// High and low 300 ns each, a 600 ns cycle
	task automatic strobe();
		@(posedge clock);
		lowpower_refresh_strobe <= 1'b1;
		repeat (6) @(posedge clock);
		lowpower_refresh_strobe <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ---- sim/dram_init_power_refresh_tb.sv ----
// Self-checking bench for the start-up, power and refresh core
`timescale 1ns/1ns
`default_nettype none
module dram_init_power_refresh_tb;
	import dram_pkg::*;
	localparam int LK = 10;
	logic clock, resetn, reg_wr, reg_rd, link_clk, cmd_wire, lowpower_refresh_strobe;
	logic locked, refresh_pulse, calib_pulse, calibrated;
	logic [8:0] bus_data;
	logic [2:0] reg_addr, power_mode;
	logic [15:0] reg_wdata, reg_rdata;
	logic [1:0] refresh_bank;
	logic [7:0] refresh_row;
	int fails, tests_run;
	dram_init_power_refresh #(.LOCK_CYCLES(LK)) i_dut (.clock, .resetn, .link_clk, .cmd_wire, .bus_data,
		.lowpower_refresh_strobe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_mode,
		.locked, .refresh_pulse, .refresh_bank, .refresh_row, .calib_pulse, .calibrated);
	ctrl_model i_ctrl (.clock, .link_clk, .cmd_wire, .bus_data, .lowpower_refresh_strobe);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		#2000000;
		fails++;
		print_verdict();
	end
	task automatic print_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata & m, e);
	endtask
	function automatic logic [35:0] req(input logic [5:0] op, input logic ac, input logic au,
		input logic [3:0] dev, input logic [1:0] bk, input logic [7:0] rw);
		return {1'b1, ac, au, op, 1'b0, MASK_NONE, dev, bk, 3'h0, 1'b0, rw};
	endfunction
	task automatic wmode(input logic [2:0] m, output int n);
		n = 0;
		while (power_mode !== m && n < 4000) begin
			@(posedge clock);
			#1 n++;
		end
	endtask
	// Sends one request and watches for its pulse meanwhile, since the pulse is one cycle
	task automatic xfer(input logic [35:0] w, input bit cal, output logic s);
		s = 1'b0;
		fork
			i_ctrl.pkt(3'h0, 1'b0, w);
			for (int i = 0; i < 300 && s !== 1'b1; i++) begin
				@(posedge clock);
				#1 s = cal ? calib_pulse : refresh_pulse;
			end
		join
		i_ctrl.idle();
	endtask
	task automatic t_start();
		int n;
		rc("mode_rst", REG_MODE, 16'hffff, 16'h0001);
		rc("devid_rst", REG_DEVID, 16'hffff, 16'h0000);
		wr(REG_REFPTR, 16'h8000);
		i_ctrl.pkt(3'h0, 1'b0, req(OP_CAL, 0, 0, 4'h0, 2'h0, CAL_COL));
		i_ctrl.idle();
		rc("drop_off", REG_STATUS, 16'h0020, 16'h0020);
		repeat (RESET_PKTS_MIN) i_ctrl.pkt(CMD_RESET, 1'b1, '0);
		fork
			i_ctrl.idle();
			wmode(3'h1, n);
		join
		chk("lock_entry", power_mode, 3'h1);
		wmode(3'h2, n);
		chk("lock_time", 16'(n >= LK - 2 && n <= LK + 2), 16'h1);
		rc("locked", REG_STATUS, 16'h0018, 16'h0008);
		wr(REG_STATUS, 16'h0020);
		rc("drop_clr", REG_STATUS, 16'h0020, 16'h0000);
		rc("unmapped", 3'h6, 16'hffff, 16'h0000);
	endtask
	task automatic t_refresh();
		logic s;
		xfer(req(OP_REFRESH, 1, 1, 4'h9, 2'h2, 8'h5a), 0, s);
		chk("ref_pulse", s, 1'b1);
		chk("ref_addr", {refresh_bank, refresh_row}, 10'h25a);
		repeat (136) @(posedge clock);
		rc("ref_cnt", REG_REFCNT, 16'hffff, 16'h0001);
	endtask
	task automatic t_calib();
		logic s;
		wr(REG_DEVID, 16'h0003);
		xfer(req(OP_CAL, 0, 0, 4'h5, 2'h0, CAL_COL), 1, s);
		chk("cal_other", s, 1'b0);
		for (int i = 0; i < CAL_BURST; i++) begin
			chk("cal_early", calibrated, 1'b0);
			xfer(req(OP_CAL, 0, 0, 4'h3, 2'h0, CAL_COL), 1, s);
			chk("cal_pulse", s, 1'b1);
			repeat (72) @(posedge clock);
		end
		chk("calibrated", calibrated, 1'b1);
		rc("cal_cnt", REG_CALCNT, 16'h00ff, 16'h0040);
		chk("stay_en", power_mode, 3'h2);
	endtask
	task automatic t_suspend();
		logic s;
		wr(REG_MODE, 16'h0000);
		xfer(req(OP_CAL, 0, 0, 4'h3, 2'h0, CAL_COL), 1, s);
		repeat (72) @(posedge clock);
		chk("suspend", power_mode, 3'h3);
		xfer(req(OP_CAL, 0, 0, 4'h3, 2'h0, CAL_COL), 1, s);
		chk("no_wake", s, 1'b0);
		rc("drop_susp", REG_STATUS, 16'h0020, 16'h0020);
		i_ctrl.pkt(CMD_WAKE, 1'b1, '0);
		xfer(req(OP_CAL, 0, 0, 4'h3, 2'h0, CAL_COL), 1, s);
		chk("woken", s, 1'b1);
		repeat (72) @(posedge clock);
		chk("resuspend", power_mode, 3'h3);
	endtask
	task automatic t_power();
		int n;
		wr(REG_REFPTR, 16'h83ff);
		@(posedge clock);
		#1 chk("pd", power_mode, 3'h4);
		i_ctrl.strobe();
		chk("self_0", {refresh_bank, refresh_row}, 10'h3ff);
		i_ctrl.strobe();
		chk("self_wrap", {refresh_bank, refresh_row}, 10'h000);
		i_ctrl.strobe();
		chk("self_bank", {refresh_bank, refresh_row}, 10'h100);
		repeat (WAKE_PKTS_MIN) i_ctrl.pkt(CMD_PDWK, 1'b1, '0);
		fork
			i_ctrl.idle();
			wmode(3'h1, n);
		join
		chk("relock", power_mode, 3'h1);
		wmode(3'h2, n);
		chk("pd_exit", power_mode, 3'h2);
		chk("cal_lost", calibrated, 1'b0);
	endtask
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		resetn = 1'b0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		t_start();
		t_refresh();
		t_calib();
		t_suspend();
		t_power();
		print_verdict();
	end
endmodule
`default_nettype wire
